// [design/ist_consts.svh]
// Register map, field positions and reset values of the second status register block
`ifndef IST_CONSTS_SVH
`define IST_CONSTS_SVH
// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define IST_ADDR_W 12
`define IST_OFS_STATUS_TWO 12'h000
`define IST_OFS_CONTROL 12'h004
// ----------------------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------------------
`define IST_ACK_FAIL_BIT 4
`define IST_STOP_SEEN_BIT 3
`define IST_ARB_LOST_BIT 2
`define IST_BUS_ERR_BIT 1
`define IST_GEN_CALL_BIT 0
`define IST_RESERVED_ZERO 3'h0
// ----------------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------------
`define IST_IFACE_ON_BIT 0
`define IST_IRQ_ALLOW_BIT 1
`define IST_GC_ACCEPT_BIT 2
`define IST_REPLY_EN_BIT 3
`define IST_CTRL_W 4
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define IST_FLAGS_RESET 5'h00
`define IST_CTRL_RESET 4'h0
`define IST_RDATA_RESET 32'h0000_0000
`endif

// [design/ist_pkg.sv]
// Types shared by the second status register block
package ist_pkg;

    // Event flags held in the status register, msb first
    typedef struct packed {
        logic ack_failure_flag;
        logic stop_seen_flag;
        logic arbitration_lost_flag;
        logic bus_error_flag;
        logic general_call_seen;
    } ist_flags_t;

    // Software control bits, msb first
    typedef struct packed {
        logic reply_enable;
        logic general_call_accept;
        logic irq_allow;
        logic interface_on;
    } ist_ctrl_t;

    // One-cycle event pulses from the bit-level protocol engine
    typedef struct packed {
        logic no_ack_seen;
        logic stop_cond;
        logic sda_mismatch;
        logic misplaced_cond;
        logic gen_call_addr;
        logic start_generated;
    } ist_events_t;

    // Level qualifiers from the protocol engine
    typedef struct packed {
        logic last_bit_acked;
        logic master_receive;
        logic in_ack_bit;
        logic start_sent_flag;
        logic byte_done_flag;
    } ist_levels_t;

endpackage

// [design/ist_status_two.sv]
// Second status register of the multimaster I2C interface, with APB slave and clock hold logic
//
// Functional notes
// - Status bits 7:5 always read zero, writes have no effect.
// - Missing acknowledge sets ack failure flag, interrupts when allowed.
// - Software status read or interface off clears first four flags.
// - Ack failure never holds the serial clock by itself.
// - Slave-mode stop after acknowledge with reply enabled sets stop flag.
// - Stop, arbitration and bus error flags never hold the clock.
// - Losing arbitration to another master sets arbitration lost flag.
// - Arbitration loss drops the master role back to slave.
// - No arbitration during master-receive acknowledge bit.
// - Misplaced start or stop sets the bus error flag.
// - Master should issue stop or repeated start after bus error.
// - General call address in slave mode with acceptance sets flag.
// - General call flag clears only on stop or interface off.
// - Serial clock held low while the byte done flag is set and the interface is on.
`include "ist_consts.svh"

module ist_status_two (
    input wire logic sys_clk,                       // 200 MHz system clock
    input wire logic rst,                           // Synchronous reset, active high
    input wire logic psel,                          // APB select
    input wire logic penable,                       // APB enable
    input wire logic pwrite,                        // APB write direction
    input wire logic [`IST_ADDR_W-1:0] paddr,       // APB byte address
    input wire logic [31:0] pwdata,                 // APB write data
    output logic [31:0] prdata,                     // APB read data
    output logic pready,                            // APB ready
    output logic pslverr,                           // APB error on unmapped address
    input wire ist_pkg::ist_events_t bus_events,    // Event pulses from protocol engine
    input wire ist_pkg::ist_levels_t bus_levels,    // Levels from protocol engine
    output logic scl_hold_low,                      // Hold serial clock low
    output logic master_role,                       // Interface acts as bus master
    output logic recover_stop_req,                  // Pulse asking engine for a stop
    output logic irq                                // Interrupt request, active high
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    ist_pkg::ist_flags_t flags_q;
    ist_pkg::ist_flags_t flags_d;
    ist_pkg::ist_ctrl_t ctrl_q;
    ist_pkg::ist_ctrl_t ctrl_d;
    logic master_q;
    logic master_d;
    logic irq_q;
    logic irq_d;
    logic hold_q;
    logic hold_d;
    logic recover_q;
    logic recover_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic access_done;
    logic hit_status;
    logic hit_control;
    logic status_read;
    logic control_write;
    logic arb_lost_ev;
    logic stop_flag_ev;
    logic gen_call_ev;
    logic [7:0] status_byte;

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------

    // A transfer completes on the edge where ready is seen with select and enable
    assign access_done = psel & penable & pready_q;
    assign hit_status = (paddr == `IST_OFS_STATUS_TWO);
    assign hit_control = (paddr == `IST_OFS_CONTROL);
    assign status_read = access_done & ~pwrite & hit_status;
    assign control_write = access_done & pwrite & hit_control;

    // Status byte as seen by software; upper bits are tied off
    assign status_byte = {`IST_RESERVED_ZERO, flags_q};

    // One wait state: ready rises one cycle into the access phase and drops after
    always_comb
    begin
        pready_d = psel & penable & ~pready_q;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        if (psel & penable & ~pready_q)
        begin
            pslverr_d = ~(hit_status | hit_control);
            if (pwrite)
            begin
                prdata_d = `IST_RDATA_RESET;
            end
            else if (hit_status)
            begin
                prdata_d = {24'h00_0000, status_byte};
            end
            else if (hit_control)
            begin
                prdata_d = {28'h000_0000, ctrl_q};
            end
            else
            begin
                prdata_d = `IST_RDATA_RESET;
            end
        end
    end

    // Bus answer registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= `IST_RDATA_RESET;
        end
        else
        begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // ------------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------------

    // Software-owned bits; a write to the status address is dropped on purpose
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (control_write)
        begin
            ctrl_d.interface_on = pwdata[`IST_IFACE_ON_BIT];
            ctrl_d.irq_allow = pwdata[`IST_IRQ_ALLOW_BIT];
            ctrl_d.general_call_accept = pwdata[`IST_GC_ACCEPT_BIT];
            ctrl_d.reply_enable = pwdata[`IST_REPLY_EN_BIT];
        end
    end

    // Control storage
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_q <= `IST_CTRL_RESET;
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    // ------------------------------------------------------------------------
    // Event qualification
    // ------------------------------------------------------------------------

    // The ack bit of a master receive is not arbitrated, so a mismatch there
    // cannot flag a loss; a second master reading the same data goes unnoticed
    assign arb_lost_ev = bus_events.sda_mismatch & master_q
        & ~(bus_levels.master_receive & bus_levels.in_ack_bit);

    // Stop only counts in slave mode after an acknowledge with replies enabled
    assign stop_flag_ev = bus_events.stop_cond & ~master_q
        & bus_levels.last_bit_acked & ctrl_q.reply_enable;

    // General call is a slave-side event and needs acceptance switched on
    assign gen_call_ev = bus_events.gen_call_addr & ~master_q
        & ctrl_q.general_call_accept;

    // ------------------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------------------

    // Clear first, then set, so an event in the clearing cycle survives the read.
    // Switching the interface off wins over everything: engine events are stale then.
    always_comb
    begin
        flags_d = flags_q;
        if (status_read)
        begin
            flags_d.ack_failure_flag = 1'b0;
            flags_d.stop_seen_flag = 1'b0;
            flags_d.arbitration_lost_flag = 1'b0;
            flags_d.bus_error_flag = 1'b0;
        end
        if (bus_events.stop_cond)
        begin
            flags_d.general_call_seen = 1'b0;
        end
        if (bus_events.no_ack_seen)
        begin
            flags_d.ack_failure_flag = 1'b1;
        end
        if (stop_flag_ev)
        begin
            flags_d.stop_seen_flag = 1'b1;
        end
        if (arb_lost_ev)
        begin
            flags_d.arbitration_lost_flag = 1'b1;
        end
        if (bus_events.misplaced_cond)
        begin
            flags_d.bus_error_flag = 1'b1;
        end
        if (gen_call_ev)
        begin
            flags_d.general_call_seen = 1'b1;
        end
        if (~ctrl_q.interface_on)
        begin
            flags_d = `IST_FLAGS_RESET;
        end
    end

    // Flag storage
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            flags_q <= `IST_FLAGS_RESET;
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    // ------------------------------------------------------------------------
    // Master role
    // ------------------------------------------------------------------------

    // Set by a generated start, dropped by stop, lost arbitration or disable.
    // Arbitration loss takes priority over a start in the same cycle.
    always_comb
    begin
        master_d = master_q;
        if (bus_events.start_generated)
        begin
            master_d = 1'b1;
        end
        if (bus_events.stop_cond | arb_lost_ev)
        begin
            master_d = 1'b0;
        end
        if (~ctrl_q.interface_on)
        begin
            master_d = 1'b0;
        end
    end

    // Master role storage
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            master_q <= 1'b0;
        end
        else
        begin
            master_q <= master_d;
        end
    end

    // ------------------------------------------------------------------------
    // Clock hold, recovery request and interrupt
    // ------------------------------------------------------------------------

    // Only start sent and byte done stretch the clock; the event flags of this
    // register are kept out so a stuck flag can never lock up the bus
    always_comb
    begin
        hold_d = ctrl_q.interface_on
            & (bus_levels.byte_done_flag
            | bus_levels.start_sent_flag);
    end

    // While master, a bus error asks the engine for a stop to free the bus
    always_comb
    begin
        recover_d = bus_events.misplaced_cond & master_q & ctrl_q.interface_on;
    end

    // Interrupt from the four software-cleared flags; general call is left out
    always_comb
    begin
        irq_d = ctrl_q.irq_allow & (flags_q.ack_failure_flag
            | flags_q.stop_seen_flag
            | flags_q.arbitration_lost_flag
            | flags_q.bus_error_flag);
    end

    // Output registers, one cycle behind their causes
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            hold_q <= 1'b0;
            recover_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            hold_q <= hold_d;
            recover_q <= recover_d;
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------

    // Every output is a flip-flop
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign scl_hold_low = hold_q;
    assign master_role = master_q;
    assign recover_stop_req = recover_q;
    assign irq = irq_q;

endmodule

// [verification/ist_bus_model.sv]
// Far-side bus model: turns bench requests into event pulses and qualifier levels
module ist_bus_model (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic recover_stop_req, // Stop request from the block
    output ist_pkg::ist_events_t bus_events, // Event pulses
    output ist_pkg::ist_levels_t bus_levels // Qualifier levels
);
    timeunit 1ns;
    timeprecision 100ps;
    int lag = 1; // Cycles before the master answers a stop request
    // Idle bus: no events, no qualifiers
    initial
    begin
        bus_events = 6'h00;
        bus_levels = 5'h00;
    end
    // One-cycle event pulse, launched just after an edge
    task automatic pulse(input ist_pkg::ist_events_t ev);
        @(posedge sys_clk);
        bus_events <= ev;
        @(posedge sys_clk);
        bus_events <= 6'h00;
    endtask
    // Level qualifiers change just after an edge
    task automatic set_lv(input ist_pkg::ist_levels_t v);
        @(posedge sys_clk);
        bus_levels <= v;
    endtask
    // Master resynchronises the bus with a stop; busy waiting hides further requests
    always @(posedge sys_clk)
    begin
        if (!rst && recover_stop_req === 1'h1)
        begin
            repeat (lag) @(posedge sys_clk);
            bus_events.stop_cond <= 1'h1;
            @(posedge sys_clk);
            bus_events.stop_cond <= 1'h0;
        end
    end
endmodule

// [verification/ist_status_two_asserts.sv]
// Concurrent checks on the ports of the second status register block
`include "ist_consts.svh"
module ist_status_two_asserts (
    input wire logic sys_clk, // Clock
    input wire logic rst, // Reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [`IST_ADDR_W-1:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire ist_pkg::ist_events_t bus_events, // Event pulses
    input wire ist_pkg::ist_levels_t bus_levels, // Levels
    input wire logic scl_hold_low, // Clock hold
    input wire logic master_role, // Master role
    input wire logic recover_stop_req, // Stop request
    input wire logic irq // Interrupt
);
    logic [3:0] ctrl_q;
    logic [3:0] ctrl_d;
    logic done;
    logic on;
    logic st_rd;
    // Shadow of control, so checks know what software allowed
    assign done = psel && penable && pready;
    assign on = ctrl_q[`IST_IFACE_ON_BIT];
    assign st_rd = done && !pwrite && paddr == `IST_OFS_STATUS_TWO;
    always_comb ctrl_d = (done && pwrite && paddr == `IST_OFS_CONTROL) ? pwdata[3:0] : ctrl_q;
    always_ff @(posedge sys_clk) ctrl_q <= rst ? 4'h0 : ctrl_d;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_RSVD_ZERO: assert property (st_rd |-> prdata[31:5] == 27'h0)
        else $error("reserved status bits not zero");
    AST_FLAG_IRQ: assert property (on && ctrl_q[1] && (bus_events.no_ack_seen || bus_events.misplaced_cond)
        |-> ##2 irq) else $error("event flag raised no interrupt");
    AST_READ_CLEAR: assert property (st_rd && bus_events[5:2] == 4'h0 |-> ##2 !irq)
        else $error("status read left interrupt up");
    AST_HOLD: assert property (1'h1 |=> scl_hold_low ==
        $past(on && (bus_levels.byte_done_flag || bus_levels.start_sent_flag))) else $error("clock hold wrong");
    AST_ARB_DROP: assert property (on && master_role && bus_events.sda_mismatch &&
        !(bus_levels.master_receive && bus_levels.in_ack_bit) |=> !master_role) else $error("role kept");
    AST_ACK_NO_ARB: assert property (on && master_role && bus_levels.master_receive &&
        bus_levels.in_ack_bit && bus_events == 6'h08 |=> master_role) else $error("role lost in ack");
    AST_RECOVER: assert property (on && master_role && bus_events.misplaced_cond |=> recover_stop_req)
        else $error("no stop request");
    AST_IRQ_GATE: assert property (!ctrl_q[`IST_IRQ_ALLOW_BIT] |=> !irq)
        else $error("interrupt not gated");
    AST_OFF_QUIET: assert property (!on |=> !master_role && !scl_hold_low ##1 !irq)
        else $error("interface off not quiet");
    AST_APB_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("wait state wrong");
    AST_SLVERR: assert property (pready |-> pslverr == (paddr != `IST_OFS_STATUS_TWO && paddr != `IST_OFS_CONTROL))
        else $error("error flag does not match address map");
    COV_ERR: cover property (done && pslverr);
    COV_ROLE: cover property ($fell(master_role));
    COV_IRQ: cover property (irq ##1 !irq);
endmodule
bind ist_status_two ist_status_two_asserts chk (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus_events, .bus_levels, .scl_hold_low, .master_role, .recover_stop_req, .irq);

// [verification/ist_status_two_tb_top.sv]
// Self-checking bench of the second status register block
`include "ist_consts.svh"
module ist_status_two_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic scl_hold_low, master_role, recover_stop_req, irq, rerr;
    logic [`IST_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    ist_pkg::ist_events_t bus_events;
    ist_pkg::ist_levels_t bus_levels;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    // Named bus patterns, so each scenario says which event or level it drives
    ist_pkg::ist_events_t e_start = '{start_generated: 1'h1, default: 1'h0};
    ist_pkg::ist_events_t e_noack = '{no_ack_seen: 1'h1, default: 1'h0};
    ist_pkg::ist_events_t e_stop = '{stop_cond: 1'h1, default: 1'h0};
    ist_pkg::ist_events_t e_mism = '{sda_mismatch: 1'h1, default: 1'h0};
    ist_pkg::ist_events_t e_bus_error_flag = '{misplaced_cond: 1'h1, default: 1'h0};
    ist_pkg::ist_events_t e_gcall = '{gen_call_addr: 1'h1, default: 1'h0};
    ist_pkg::ist_levels_t l_idle = '{default: 1'h0};
    ist_pkg::ist_levels_t l_rx_ack = '{master_receive: 1'h1, in_ack_bit: 1'h1, default: 1'h0};
    ist_pkg::ist_levels_t l_acked = '{last_bit_acked: 1'h1, default: 1'h0};
    ist_pkg::ist_levels_t l_done = '{byte_done_flag: 1'h1, default: 1'h0};
    ist_pkg::ist_levels_t l_start = '{start_sent_flag: 1'h1, default: 1'h0};
    localparam logic [11:0] ST = `IST_OFS_STATUS_TWO;
    localparam logic [11:0] CT = `IST_OFS_CONTROL;
    ist_status_two DUT (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .bus_events, .bus_levels, .scl_hold_low, .master_role, .recover_stop_req, .irq);
    ist_bus_model bm (.sys_clk, .rst, .recover_stop_req, .bus_events, .bus_levels);
    // 200 MHz clock
    initial
    begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Hang guard: a stuck handshake ends the run as a failure
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer; the request holds until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        @(posedge sys_clk);
        while (pready !== 1'h1) @(posedge sys_clk);
        rv = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rv, e);
    endtask
    // Let an event reach the flags and the interrupt
    task automatic settle;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic t_regs;
        apb(1'h1, ST, 32'hffff_ffff);
        rd_chk(ST, 32'h0);
        rd_chk(CT, 32'h0);
        rd_chk(12'h008, 32'h0);
        chk(32'(rerr), 32'h1);
    endtask
    task automatic t_ack;
        apb(1'h1, CT, 32'h3);
        bm.pulse(e_start);
        bm.pulse(e_noack);
        settle();
        chk(32'(irq), 32'h1);
        chk(32'(scl_hold_low), 32'h0);
        rd_chk(ST, 32'h10);
        rd_chk(ST, 32'h0);
        chk(32'(irq), 32'h0);
        // Software frees the lines itself after the failure, which ends the transfer with a stop
        bm.pulse(e_stop);
        settle();
        chk(32'(master_role), 32'h0);
    endtask
    task automatic t_arb;
        bm.pulse(e_start);
        bm.set_lv(l_rx_ack);
        bm.pulse(e_mism);
        settle();
        chk(32'(master_role), 32'h1);
        rd_chk(ST, 32'h0);
        bm.set_lv(l_idle);
        bm.pulse(e_mism);
        settle();
        chk(32'(master_role), 32'h0);
        rd_chk(ST, 32'h04);
    endtask
    task automatic t_gc;
        apb(1'h1, CT, 32'hf);
        bm.set_lv(l_acked);
        bm.pulse(e_gcall);
        settle();
        chk(32'(irq), 32'h0);
        rd_chk(ST, 32'h01);
        rd_chk(ST, 32'h01);
        bm.pulse(e_stop);
        settle();
        rd_chk(ST, 32'h08);
        rd_chk(ST, 32'h0);
    endtask
    // Bus error as master, with a prompt and a slow far side
    task automatic t_bus_error_flag;
        bm.set_lv(l_idle);
        for (int l = 0; l < 4; l += 3)
        begin
            bm.lag = l;
            bm.pulse(e_start);
            bm.pulse(e_bus_error_flag);
            repeat (8) @(posedge sys_clk);
            #1;
            chk(32'(master_role), 32'h0);
            rd_chk(ST, 32'h02);
        end
    endtask
    task automatic t_hold;
        bm.set_lv(l_done);
        settle();
        chk(32'(scl_hold_low), 32'h1);
        bm.set_lv(l_start);
        bm.pulse(e_bus_error_flag);
        settle();
        chk(32'(scl_hold_low), 32'h1);
        bm.set_lv(l_idle);
        settle();
        chk(32'(scl_hold_low), 32'h0);
        apb(1'h1, CT, 32'h0);
        bm.set_lv(l_done);
        settle();
        chk(32'(scl_hold_low), 32'h0);
        rd_chk(ST, 32'h0);
    endtask
    // Reset, then the scenarios in turn
    initial
    begin
        rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (10) @(posedge sys_clk);
        rst <= 1'h0;
        t_regs();
        t_ack();
        t_arb();
        t_gc();
        t_bus_error_flag();
        t_hold();
        report_and_stop();
    end
endmodule
